// ---- hdl/pfp_protect_ctrl.sv ----
// Program flash protection control: protection byte, violation flag,
// interrupt status and the program/erase admission check.
// Assumes an APB master, and a nonvolatile reader and command controller on pclk.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps

// How it works
// - Reset sequence loads byte from configuration address
// - Double fault loads full protection instead
// - Protected program/erase refused, violation flag set
// - Block erase refused if anything protected
// - Bit 7 chooses protected or unprotected ranges
// - Bit 5 disables the top range
// - High size writable only while high disabled
// - Bit 2 disables the low range
// - Low size writable only while low disabled
// - High size codes give 2 to 16 KB
// - Low size codes give 1 to 8 KB
// - Three control bits decode eight protection functions
// - Disallowed scenario write ignored completely
// - Transition table limits scenario changes
// - Violation flag write-one-clear, blocks launches
module pfp_protect_ctrl
    import pfp_pkg::*;
#(
    parameter logic [22:0] PF_BASE = pfp_pkg::PF_BASE_DEF
)
(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Nonvolatile configuration read during the reset sequence
    output logic             nv_rd_req,
    output logic [22:0]      nv_rd_addr,
    input  wire logic        nv_rd_done,
    input  wire logic [7:0]  nv_rd_data,
    input  wire logic        nv_rd_dbl_fault,
    // Program or erase admission
    input  wire logic        pe_req,
    input  wire logic        pe_block_erase,
    input  wire logic [22:0] pe_addr,
    output logic             pe_accept,
    output logic             pe_refuse,
    // Status outputs
    output logic [7:0]       prot_out,
    output logic             launch_blocked,
    output logic             irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    pfp_state_t  state;
    logic [7:0]  prot;
    logic        viol;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        held;

    function automatic logic [2:0] scen_of(input logic [7:0] v);
        scen_of = SCEN_OF_CODE[{v[BIT_OPEN], v[BIT_HDIS], v[BIT_LDIS]}];
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic [5:0] idx;
    logic       hit_status;
    logic       hit_prot;
    logic       hit_irq_stat;
    logic       hit_irq_en;
    logic       hit_irq_clr;
    logic       mapped;
    logic       access;
    logic       wr_lo;
    logic [31:0] rd_mux;

    assign idx          = paddr[7:2];
    assign hit_status   = (idx == IDX_STATUS);
    assign hit_prot     = (idx == IDX_PROT);
    assign hit_irq_stat = (idx == IDX_IRQ_STAT);
    assign hit_irq_en   = (idx == IDX_IRQ_EN);
    assign hit_irq_clr  = (idx == IDX_IRQ_CLR);
    assign mapped       = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0)
                          && (hit_status || hit_prot || hit_irq_stat || hit_irq_en || hit_irq_clr);
    // Read data is captured one cycle ahead, so the answer waits for that capture
    assign pready       = ce && psel && penable && held;
    assign access       = pready;
    assign pslverr      = access && !mapped;
    assign wr_lo        = access && pwrite && mapped && pstrb[0];

    assign rd_mux = hit_status   ? {27'h000_0000, viol, 4'h0} :
                    hit_prot     ? {24'h00_0000, prot} :
                    hit_irq_stat ? {30'h0000_0000, irq_stat} :
                    hit_irq_en   ? {30'h0000_0000, irq_en} :
                                   32'h0000_0000;

    // ****************************************************************
    // Protection byte write filter
    // ****************************************************************
    logic [7:0] wr_val;
    logic       wr_legal;
    logic       prot_wr;

    assign wr_val[BIT_OPEN]              = pwdata[BIT_OPEN];
    assign wr_val[BIT_RSV]               = prot[BIT_RSV];
    assign wr_val[BIT_HDIS]              = pwdata[BIT_HDIS];
    assign wr_val[BIT_HS_HI:BIT_HS_LO]   = prot[BIT_HDIS] ? pwdata[BIT_HS_HI:BIT_HS_LO]
                                                          : prot[BIT_HS_HI:BIT_HS_LO];
    assign wr_val[BIT_LDIS]              = pwdata[BIT_LDIS];
    assign wr_val[BIT_LS_HI:BIT_LS_LO]   = prot[BIT_LDIS] ? pwdata[BIT_LS_HI:BIT_LS_LO]
                                                          : prot[BIT_LS_HI:BIT_LS_LO];
    assign wr_legal = SCEN_ALLOWED[scen_of(prot)][scen_of(wr_val)];
    // Illegal scenarios leave the byte untouched, size fields included
    assign prot_wr  = wr_lo && hit_prot && (state == PFP_RUN) && wr_legal;

    // ****************************************************************
    // Program and erase admission
    // ****************************************************************
    logic addr_prot;
    logic any_prot;
    logic prot_hit;
    logic viol_set;
    logic viol_clr;
    logic load_now;
    logic nv_fault_ev;

    pfp_range_check #(
        .PF_BASE        (PF_BASE)
    ) u_range (
        .prot           (prot),
        .addr           (pe_addr),
        .addr_protected (addr_prot),
        .any_protected  (any_prot)
    );

    // Checks run on the byte as it stands in this cycle
    assign prot_hit  = addr_prot || (pe_block_erase && any_prot);
    assign pe_refuse = ce && pe_req && ((state != PFP_RUN) || viol || prot_hit);
    assign pe_accept = ce && pe_req && !pe_refuse;
    assign viol_set  = ce && pe_req && (state == PFP_RUN) && prot_hit;
    assign viol_clr  = wr_lo && hit_status && pwdata[BIT_VIOL];
    assign load_now  = ce && (state == PFP_LOAD) && nv_rd_done;
    assign nv_fault_ev = load_now && nv_rd_dbl_fault;

    // ****************************************************************
    // Next values
    // ****************************************************************
    logic [7:0] next_prot;
    logic       next_viol;
    logic [1:0] next_irq_stat;
    logic [1:0] irq_ev;
    logic [1:0] irq_clr;

    // Fault forces open clear and all other bits set
    assign next_prot = load_now ? (nv_rd_dbl_fault ? PROT_FULL : nv_rd_data) :
                       prot_wr  ? wr_val : prot;
    // Setting wins over a clear in the same cycle
    assign next_viol = viol_set || (viol && !viol_clr);
    assign irq_ev[IRQ_VIOL]     = viol_set;
    assign irq_ev[IRQ_NV_FAULT] = nv_fault_ev;
    assign irq_clr       = (wr_lo && hit_irq_clr) ? pwdata[1:0] : 2'h0;
    assign next_irq_stat = irq_ev | (irq_stat & ~irq_clr);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= PFP_LOAD;
            prot  <= PROT_FULL;
            viol  <= 1'b0;
        end
        else if (ce)
        begin
            unique case (state)
                PFP_LOAD:
                begin
                    if (nv_rd_done)
                    begin
                        state <= PFP_RUN;
                    end
                end
                PFP_RUN:
                begin
                    state <= PFP_RUN;
                end
            endcase
            prot <= next_prot;
            viol <= next_viol;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat <= 2'h0;
            irq_en   <= 2'h0;
            held     <= 1'b0;
            prdata   <= 32'h0000_0000;
        end
        else if (ce)
        begin
            irq_stat <= next_irq_stat;
            if (wr_lo && hit_irq_en)
            begin
                irq_en <= pwdata[1:0];
            end
            held <= psel && !access;
            if (psel && !held)
            begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_rd_req  <= 1'b0;
            nv_rd_addr <= NV_CFG_ADDR;
        end
        else if (ce)
        begin
            nv_rd_req  <= (state == PFP_LOAD) && !nv_rd_done;
            nv_rd_addr <= NV_CFG_ADDR;
        end
    end

    assign prot_out       = prot;
    assign launch_blocked = viol;
    assign irq            = |(irq_stat & irq_en);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_load_clean;
        ce && state == PFP_LOAD && nv_rd_done && !nv_rd_dbl_fault;
    endsequence

    sequence s_load_fault;
        ce && state == PFP_LOAD && nv_rd_done && nv_rd_dbl_fault;
    endsequence

    sequence s_prot_write(logic ok);
        ce && access && pwrite && pstrb[0] && hit_prot && state == PFP_RUN && wr_legal == ok;
    endsequence

    chk_load_value: assert property (s_load_clean
        |=> prot == $past(nv_rd_data) && state == PFP_RUN)
        else $error("protection byte not loaded from configuration");
    chk_fault_full: assert property (s_load_fault
        |=> prot == PROT_FULL && irq_stat[IRQ_NV_FAULT])
        else $error("double fault did not give full protection");
    chk_viol_set: assert property (ce && pe_req && state == PFP_RUN && addr_prot
        |-> pe_refuse ##1 viol)
        else $error("protected program not refused or flag not set");
    chk_block_erase: assert property (ce && pe_req && pe_block_erase && any_prot
        |-> !pe_accept)
        else $error("block erase accepted while protected");
    chk_open_meaning: assert property (pe_req && prot[BIT_OPEN] && prot[BIT_HDIS]
        && prot[BIT_LDIS] |-> !addr_prot)
        else $error("open set with no ranges still protects");
    chk_high_size: assert property (s_prot_write(1'b1) ##0 !prot[BIT_HDIS]
        |=> $stable(prot[BIT_HS_HI:BIT_HS_LO]))
        else $error("high size changed while high range enabled");
    chk_low_size: assert property (s_prot_write(1'b1) ##0 !prot[BIT_LDIS]
        |=> $stable(prot[BIT_LS_HI:BIT_LS_LO]))
        else $error("low size changed while low range enabled");
    chk_bad_ignored: assert property (s_prot_write(1'b0) |=> $stable(prot))
        else $error("disallowed scenario write changed the byte");
    chk_full_sink: assert property (state == PFP_RUN && scen_of(prot) == 3'h3 && !load_now
        |=> scen_of(prot) == 3'h3)
        else $error("left the fully protected scenario");
    chk_viol_blocks: assert property (viol && ce && pe_req |-> pe_refuse && !pe_accept)
        else $error("launch accepted while violation flag set");
    chk_viol_sticky: assert property (viol && ce && !viol_clr |=> viol)
        else $error("violation flag dropped without clear");

endmodule

// ---- common/pfp_pkg.sv ----
// Shared constants for the program flash protection control block.
// Assumes a 32-bit APB slave, one clock domain and a same-clock nonvolatile reader.
package pfp_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_STATUS   = 6'h06;
    localparam logic [5:0] IDX_PROT     = 6'h08;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
    localparam logic [5:0] IDX_IRQ_EN   = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLR  = 6'h12;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_OPEN     = 7;
    localparam int BIT_RSV      = 6;
    localparam int BIT_HDIS     = 5;
    localparam int BIT_HS_HI    = 4;
    localparam int BIT_HS_LO    = 3;
    localparam int BIT_LDIS     = 2;
    localparam int BIT_LS_HI    = 1;
    localparam int BIT_LS_LO    = 0;
    localparam int BIT_VIOL     = 4;
    localparam int IRQ_VIOL     = 0;
    localparam int IRQ_NV_FAULT = 1;

    // ****************************************************************
    // Reset values and addresses
    // ****************************************************************
    localparam logic [7:0]  PROT_FULL      = 8'h7F;
    localparam logic [22:0] NV_CFG_ADDR    = 23'h7F_FF0C;
    localparam logic [22:0] PF_TOP         = 23'h7F_FFFF;
    localparam logic [22:0] PF_BASE_DEF    = 23'h7C_0000;
    localparam logic [22:0] LOW_BASE       = 23'h7F_8000;
    localparam logic [22:0] HIGH_MIN_BYTES = 23'h00_0800;
    localparam logic [22:0] LOW_MIN_BYTES  = 23'h00_0400;

    // Scenario index held by each {open, high disable, low disable} code
    localparam logic [2:0] SCEN_OF_CODE [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                               3'h4, 3'h5, 3'h6, 3'h7};
    // Bit n of entry f set: scenario f may move to scenario n
    localparam logic [7:0] SCEN_ALLOWED [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                               8'h18, 8'h3C, 8'h5A, 8'hFF};

    typedef enum logic {PFP_LOAD, PFP_RUN} pfp_state_t;

endpackage

// ---- hdl/pfp_range_check.sv ----
// Address check against the program flash protection byte.
// Purely combinational; the caller supplies the register as it stands this cycle.
`timescale 1ns/1ps
module pfp_range_check
    import pfp_pkg::*;
#(
    parameter logic [22:0] PF_BASE = PF_BASE_DEF
)
(
    // Protection byte and address under test
    input  wire logic [7:0]  prot,
    input  wire logic [22:0] addr,
    // Results
    output logic             addr_protected,
    output logic             any_protected
);

    logic [22:0] high_start;
    logic [22:0] low_end;
    logic        in_pflash;
    logic        high_hit;
    logic        low_hit;
    logic        range_hit;

    // ****************************************************************
    // Range bounds
    // ****************************************************************
    assign high_start = PF_TOP - ((HIGH_MIN_BYTES << prot[BIT_HS_HI:BIT_HS_LO]) - 23'h00_0001);
    assign low_end    = LOW_BASE + ((LOW_MIN_BYTES << prot[BIT_LS_HI:BIT_LS_LO]) - 23'h00_0001);
    assign in_pflash  = (addr >= PF_BASE);
    assign high_hit   = !prot[BIT_HDIS] && (addr >= high_start);
    assign low_hit    = !prot[BIT_LDIS] && (addr >= LOW_BASE) && (addr <= low_end);
    assign range_hit  = high_hit || low_hit;

    // Open set: ranges are protected; open clear: ranges are the only holes
    assign addr_protected = in_pflash && (prot[BIT_OPEN] ? range_hit : !range_hit);
    // Only the fully open code leaves every sector of the block writable
    assign any_protected  = !(prot[BIT_OPEN] && prot[BIT_HDIS] && prot[BIT_LDIS]);

endmodule

// ---- verif/pfp_nv_model.sv ----
// Behavioural nonvolatile configuration reader facing the protection block.
// Assumes the bench sets byte, fault and latency before reset is released.
`timescale 1ns/1ps
module pfp_nv_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Read port of the block
    input  wire logic        nv_rd_req,
    input  wire logic [22:0] nv_rd_addr,
    output logic             nv_rd_done,
    output logic [7:0]       nv_rd_data,
    output logic             nv_rd_dbl_fault,
    // Bench settings
    input  wire logic [7:0]  cfg_byte,
    input  wire logic        cfg_fault,
    input  wire logic [3:0]  latency,
    output logic             loaded
);
    logic [3:0] wait_cnt;

    // Answers only the configuration address, once per reset; data is
    // inverted outside the answer so a late sample never looks valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt        <= 4'h0;
            nv_rd_done      <= 1'b0;
            nv_rd_data      <= 8'h00;
            nv_rd_dbl_fault <= 1'b0;
            loaded          <= 1'b0;
        end
        else if (nv_rd_req && !loaded && nv_rd_addr == 23'h7F_FF0C && wait_cnt == latency)
        begin
            nv_rd_done      <= 1'b1;
            nv_rd_data      <= cfg_byte;
            nv_rd_dbl_fault <= cfg_fault;
            loaded          <= 1'b1;
        end
        else
        begin
            if (nv_rd_req && !loaded)
                wait_cnt <= wait_cnt + 4'h1;
            nv_rd_done      <= 1'b0;
            nv_rd_data      <= ~nv_rd_data;
            nv_rd_dbl_fault <= ~nv_rd_dbl_fault;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the program flash protection control block.
// Assumes the nonvolatile reader model and an APB master on one clock.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module tb_top;
    import pfp_pkg::*;
    typedef struct packed {logic [7:0] wd; logic [7:0] ep; logic [22:0] a; logic blk; logic rf;}
        pfp_row_t;
    // *****
    // Signals
    // *****
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        pe_req = 1'b0;
    logic        pe_block_erase = 1'b0;
    logic [22:0] pe_addr = 23'h00_0000;
    logic [7:0]  cfg_byte = 8'hFF;
    logic        cfg_fault = 1'b0;
    logic        pready, pslverr, nv_rd_req, nv_rd_done, nv_rd_dbl_fault, loaded, err;
    logic        pe_accept, pe_refuse, launch_blocked, irq;
    logic [31:0] prdata, rd;
    logic [22:0] nv_rd_addr;
    logic [7:0]  nv_rd_data, prot_out, from_b, to_b;
    int          error_cnt = 0;
    int          tests_run = 0;
    // Bit t of entry f: scenario f may move to scenario t
    localparam logic [7:0] allow_tbl [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                             8'h18, 8'h3C, 8'h5A, 8'hFF};
    // Write, expected byte, request address, block erase, refused
    pfp_row_t rows [9] = '{'{8'hE6, 8'hE6, 23'h7F_FFFF, 1'b1, 1'b0},
                           '{8'hC6, 8'hC6, 23'h7F_F800, 1'b0, 1'b1},
                           '{8'hE6, 8'hC6, 23'h7F_F7FF, 1'b0, 1'b0},
                           '{8'hDF, 8'hC7, 23'h7F_F7FF, 1'b0, 1'b0},
                           '{8'hC3, 8'hC3, 23'h7F_9FFF, 1'b0, 1'b1},
                           '{8'hC0, 8'hC3, 23'h7F_A000, 1'b0, 1'b0},
                           '{8'h63, 8'hC3, 23'h7F_A000, 1'b1, 1'b1},
                           '{8'h67, 8'h67, 23'h7C_0000, 1'b0, 1'b1},
                           '{8'hFF, 8'h67, 23'h7B_FFFF, 1'b0, 1'b0}};

    always #2 pclk = ~pclk;

    pfp_protect_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .nv_rd_req(nv_rd_req),
        .nv_rd_addr(nv_rd_addr), .nv_rd_done(nv_rd_done), .nv_rd_data(nv_rd_data),
        .nv_rd_dbl_fault(nv_rd_dbl_fault), .pe_req(pe_req), .pe_block_erase(pe_block_erase),
        .pe_addr(pe_addr), .pe_accept(pe_accept), .pe_refuse(pe_refuse),
        .prot_out(prot_out), .launch_blocked(launch_blocked), .irq(irq));

    pfp_nv_model u_nv (.pclk(pclk), .presetn(presetn), .nv_rd_req(nv_rd_req),
        .nv_rd_addr(nv_rd_addr), .nv_rd_done(nv_rd_done), .nv_rd_data(nv_rd_data),
        .nv_rd_dbl_fault(nv_rd_dbl_fault), .cfg_byte(cfg_byte), .cfg_fault(cfg_fault),
        .latency(4'h3), .loaded(loaded));
    // *****
    // Tasks
    // *****
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; the master waits for pready with no assumed latency
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {4'h0, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        @(posedge pclk);
        while (!pready)
        begin
            n++;
            if (n == 50)
            begin
                error_cnt++;
                test_done();
            end
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pe(input logic [22:0] a, input logic blk, input logic exp_ref);
        @(posedge pclk);
        pe_req         <= 1'b1;
        pe_block_erase <= blk;
        pe_addr        <= a;
        @(negedge pclk);
        `CHK("pe_refuse", exp_ref, pe_refuse)
        `CHK("pe_accept", ~exp_ref, pe_accept)
        @(posedge pclk);
        pe_req <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic do_reset(input logic [7:0] b, input logic f);
        int n = 0;
        @(posedge pclk);
        presetn   <= 1'b0;
        cfg_byte  <= b;
        cfg_fault <= f;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK("prot_pre_load", 8'h7F, prot_out)
        `CHK("nv_rd_addr", 23'h7F_FF0C, nv_rd_addr)
        while (!loaded)
        begin
            n++;
            if (n == 50)
            begin
                error_cnt++;
                test_done();
            end
            @(negedge pclk);
        end
        `CHK("nv_rd_req_on", 1'b1, nv_rd_req)
        @(negedge pclk);
        `CHK("prot_load", f ? 8'h7F : b, prot_out)
        `CHK("nv_rd_req_off", 1'b0, nv_rd_req)
    endtask

    function automatic logic [7:0] code(input int s);
        return {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
    endfunction
    // *****
    // Sequence
    // *****
    initial
    begin
        #100_000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        do_reset(8'hFF, 1'b0);
        apb(1'b1, IDX_IRQ_EN, 32'h0000_0001);
        foreach (rows[i])
        begin
            apb(1'b1, IDX_PROT, {24'h00_0000, rows[i].wd});
            apb(1'b0, IDX_PROT, 32'h0000_0000);
            `CHK("prot_read", {24'h00_0000, rows[i].ep}, rd)
            pe(rows[i].a, rows[i].blk, rows[i].rf);
            if (!rows[i].blk)
            begin
                `CHK("viol_flag", rows[i].rf, launch_blocked)
                `CHK("irq_viol", rows[i].rf, irq)
            end
            if (rows[i].rf && !rows[i].blk)
            begin
                apb(1'b1, IDX_STATUS, 32'h0000_0000);
                apb(1'b0, IDX_STATUS, 32'h0000_0000);
                `CHK("status_read", 32'h0000_0010, rd)
                pe(23'h7B_FFFF, 1'b0, 1'b1);
            end
            apb(1'b1, IDX_STATUS, 32'h0000_0010);
            apb(1'b1, IDX_IRQ_CLR, 32'h0000_0001);
            @(negedge pclk);
            `CHK("viol_clear", 1'b0, launch_blocked)
            `CHK("irq_clear", 1'b0, irq)
        end
        // Unmapped index answers with an error
        apb(1'b0, 6'h05, 32'h0000_0000);
        `CHK("pslverr", 1'b1, err)
        // Double fault: full protection, event held while masked
        do_reset(8'hFF, 1'b1);
        apb(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
        `CHK("irq_stat", 32'h0000_0002, rd)
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, IDX_IRQ_EN, 32'h0000_0002);
        @(negedge pclk);
        `CHK("irq_enabled", 1'b1, irq)
        apb(1'b1, IDX_IRQ_CLR, 32'h0000_0002);
        @(negedge pclk);
        `CHK("irq_cleared", 1'b0, irq)
        // Both ranges unprotected, largest sizes
        do_reset(8'h5B, 1'b0);
        pe(23'h7F_C000, 1'b0, 1'b0);
        pe(23'h7F_FF0C, 1'b0, 1'b0);
        pe(23'h7F_BFFF, 1'b0, 1'b1);
        // Every scenario pair, each from a fresh load
        for (int f = 0; f < 8; f++)
            for (int t = 0; t < 8; t++)
            begin
                from_b = code(f);
                to_b   = code(t);
                do_reset(from_b, 1'b0);
                pe(23'h7C_0000, 1'b1, logic'(f != 7));
                apb(1'b1, IDX_PROT, {24'h00_0000, to_b});
                @(negedge pclk);
                `CHK("prot_trans", allow_tbl[f][t] ? to_b : from_b, prot_out)
            end
        test_done();
    end
endmodule
